// ==== verilog/gtu_timer.sv ====
/*
 One timer channel with timer, event counter and one-shot modes, a
 sixteen-bit down/up counter, reload register, output pin and sticky
 interrupt status. Assumes software drives the plain register port in the
 clock_i domain and the trigger pin is asynchronous.
*/
// Our own choices: the address-and-strobe port and the placing of the registers.
module gtu_timer (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [gtu_pkg::ADDR_W-1:0] addr_i,
   input wire logic [gtu_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [gtu_pkg::DATA_W-1:0] rdata_o,
   input wire logic trigger_input_pin_i,
   input wire logic [1:0] trig_peer_i,
   output logic timer_output_pin_o,
   output logic irq_o
);
   import gtu_pkg::*;

   logic trig_sync;
   logic trig_prev_q, trig_prev_d;
   logic start_q, start_d;
   logic [7:0] mode_q, mode_d;
   logic [2:0] trigsel_q, trigsel_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] reload_q, reload_d;
   logic [CNT_W-1:0] pre_q, pre_d;
   logic [CNT_W-1:0] pdiv_q, pdiv_d;
   logic out_q, out_d;
   logic running_q, running_d;
   logic retrig_q, retrig_d;
   logic stop_req_q, stop_req_d;
   logic [IRQ_W-1:0] stat_q, stat_d;
   logic [IRQ_W-1:0] en_q, en_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [1:0] mode_sel;
   logic tick;
   logic trig_edge;
   logic trig_fire;
   logic reload_now;
   logic ovf_now;
   logic wr_start, wr_mode, wr_cnt, wr_trig;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] clr;

   // Trigger pin comes from outside the clock domain
   gtu_sync u_trig_sync (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .async_i(trigger_input_pin_i),
      .sync_o(trig_sync)
   );

   assign mode_sel = mode_q[MODE_LSB +: 2];
   assign wr_start = wr_i && (addr_i == OFS_START);
   assign wr_mode = wr_i && (addr_i == OFS_MODE);
   assign wr_cnt = wr_i && (addr_i == OFS_COUNT);
   assign wr_trig = wr_i && (addr_i == OFS_TRIG);
   assign trig_edge = trig_sync && !trig_prev_q;

   // Internal count source from a prescaler; event mode counts pin edges only with ZPH_BIT set, else prescaler ticks
   always_comb
   begin
      pdiv_d = pdiv_q;
      tick = 1'b0;
      if (!start_q)
         pdiv_d = CNT_ZERO;
      else if (pdiv_q >= pre_q)
      begin
         pdiv_d = CNT_ZERO;
         tick = 1'b1;
      end
      else
         pdiv_d = pdiv_q + CNT_ONE;
   end

   // Trigger choice: software start, pin edge, or a peer channel
   always_comb
   begin
      trig_fire = 1'b0;
      if (trigsel_q[TRG_EXT_BIT])
      begin
         unique case (trigsel_q[TRG_SEL_LSB +: 2])
            2'h0: trig_fire = trig_edge;
            2'h1: trig_fire = trig_peer_i[0];
            2'h2: trig_fire = trig_peer_i[1];
            default: trig_fire = 1'b0;
         endcase
      end
   end

   always_comb
   begin
      start_d = start_q;
      mode_d = mode_q;
      trigsel_d = trigsel_q;
      reload_d = reload_q;
      cnt_d = cnt_q;
      pre_d = pre_q;
      out_d = out_q;
      running_d = running_q;
      retrig_d = retrig_q;
      stop_req_d = 1'b0;
      trig_prev_d = trig_sync;
      reload_now = 1'b0;
      ovf_now = 1'b0;
      ev = '0;
      if (wr_start)
         start_d = wdata_i[0];
      // Mode and trigger are only honoured while stopped
      if (wr_mode && !start_q)
      begin
         mode_d = wdata_i[7:0];
         // Entering one-shot raises the request flag
         if (wdata_i[MODE_LSB +: 2] == MODE_ONESHOT &&
             mode_sel != MODE_ONESHOT)
            ev[IRQ_REQ] = 1'b1;
      end
      if (wr_trig && !start_q)
         trigsel_d = wdata_i[2:0];
      if (wr_i && addr_i == OFS_PRESCALE)
         pre_d = wdata_i[CNT_W-1:0];
      // Writes go to reload; counter follows while stopped
      if (wr_cnt)
      begin
         reload_d = wdata_i[CNT_W-1:0];
         if (!start_q)
            cnt_d = wdata_i[CNT_W-1:0];
      end
      if (wr_start && !wdata_i[0] && start_q && mode_sel == MODE_ONESHOT)
      begin
         // Software stop in one-shot
         cnt_d = reload_q;
         out_d = 1'b0;
         running_d = 1'b0;
         retrig_d = 1'b0;
         stop_req_d = 1'b1;
      end
      else if (start_q && tick)
      begin
         // Nothing moves before the start bit is set
         unique case (mode_sel)
            MODE_EVENT:
            begin
               // Gated mode: wrap is a count step too, so needs an edge
               if (trig_edge || !mode_q[ZPH_BIT])
               begin
                  if (!mode_q[DIR_BIT] && cnt_q == CNT_ZERO)
                  begin
                     cnt_d = reload_q;
                     reload_now = 1'b1;
                     ev[IRQ_UDF] = 1'b1;
                  end
                  else if (mode_q[DIR_BIT] && cnt_q == CNT_ONES)
                  begin
                     cnt_d = reload_q;
                     ovf_now = 1'b1;
                     ev[IRQ_OVF] = 1'b1;
                  end
                  else
                     cnt_d = mode_q[DIR_BIT] ? cnt_q + CNT_ONE
                                             : cnt_q - CNT_ONE;
               end
            end
            MODE_ONESHOT:
            begin
               // Output moves only on count source ticks
               if (retrig_q)
               begin
                  // One more step was taken, now reload
                  cnt_d = reload_q;
                  retrig_d = 1'b0;
               end
               else if (running_q && cnt_q == CNT_ONE)
               begin
                  cnt_d = reload_q;
                  out_d = 1'b0;
                  running_d = 1'b0;
                  ev[IRQ_REQ] = 1'b1;
               end
               else if (running_q)
               begin
                  cnt_d = cnt_q - CNT_ONE;
                  out_d = 1'b1;
               end
               if (!running_q && (trig_fire || !trigsel_q[TRG_EXT_BIT]))
               begin
                  running_d = 1'b1;
                  out_d = 1'b1;
               end
               else if (running_q && trig_fire && !retrig_q)
               begin
                  cnt_d = cnt_q - CNT_ONE;
                  retrig_d = 1'b1;
               end
            end
            default:
            begin
               // Timer mode, reload on reaching zero
               if (cnt_q == CNT_ZERO)
               begin
                  cnt_d = reload_q;
                  reload_now = 1'b1;
                  ev[IRQ_REQ] = 1'b1;
                  out_d = !out_q;
               end
               else
                  cnt_d = cnt_q - CNT_ONE;
            end
         endcase
      end
      // While the start bit is clear, in any mode, running and retrigger state are cleared
      if (!start_q)
      begin
         running_d = 1'b0;
         retrig_d = 1'b0;
      end
      // Request flag one cycle after the software stop
      if (stop_req_q)
         ev[IRQ_REQ] = 1'b1;
   end

   // Sticky status; a new event beats a same-cycle clear
   always_comb
   begin
      clr = '0;
      if (wr_i && addr_i == OFS_IRQ_CLR)
         clr = wdata_i[IRQ_W-1:0];
      stat_d = (stat_q & ~clr) | ev;
      en_d = en_q;
      if (wr_i && addr_i == OFS_IRQ_EN)
         en_d = wdata_i[IRQ_W-1:0];
   end

   // Live count reads, with the reload and overflow substitutes
   always_comb
   begin
      rdata_d = '0;
      if (rd_i)
      begin
         unique case (addr_i)
            OFS_START: rdata_d[0] = start_q;
            OFS_MODE: rdata_d[7:0] = mode_q;
            OFS_TRIG: rdata_d[2:0] = trigsel_q;
            OFS_STATUS: rdata_d[IRQ_W-1:0] = stat_q;
            OFS_IRQ_EN: rdata_d[IRQ_W-1:0] = en_q;
            OFS_PRESCALE: rdata_d[CNT_W-1:0] = pre_q;
            OFS_COUNT:
            begin
               if (reload_now)
                  rdata_d[CNT_W-1:0] = CNT_ONES;
               else if (ovf_now)
                  rdata_d[CNT_W-1:0] = CNT_ZERO;
               else
                  rdata_d[CNT_W-1:0] = cnt_q;
            end
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         start_q <= 1'b0;
         mode_q <= MODE_RST;
         trigsel_q <= '0;
         cnt_q <= CNT_ZERO;
         reload_q <= CNT_ZERO;
         pre_q <= PRESCALE_RST;
         pdiv_q <= CNT_ZERO;
         out_q <= 1'b0;
         running_q <= 1'b0;
         retrig_q <= 1'b0;
         stop_req_q <= 1'b0;
         trig_prev_q <= 1'b0;
         stat_q <= '0;
         en_q <= '0;
         rdata_q <= '0;
      end
      else
      begin
         start_q <= start_d;
         mode_q <= mode_d;
         trigsel_q <= trigsel_d;
         cnt_q <= cnt_d;
         reload_q <= reload_d;
         pre_q <= pre_d;
         pdiv_q <= pdiv_d;
         out_q <= out_d;
         running_q <= running_d;
         retrig_q <= retrig_d;
         stop_req_q <= stop_req_d;
         trig_prev_q <= trig_prev_d;
         stat_q <= stat_d;
         en_q <= en_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata_o = rdata_q;
   assign timer_output_pin_o = out_q;
   assign irq_o = |(stat_q & en_q);
endmodule

// ==== verilog/gtu_pkg.sv ====
/*
 Constants, register offsets, field positions and mode codes for a single
 general-purpose timer channel. Assumes one 25 MHz clock and a plain
 register port with read data one cycle after the read strobe.
*/
// Function
// - Channel stays stopped until start bit set
// - Counter readable at any time while counting
// - Timer mode read during reload gives ones
// - Stopped write then read returns written value
// - Event underflow reads ones, overflow zeros
// - One-shot stop halts and reloads counter
// - One-shot software stop drives output low
// - Request flag sets one cycle after stop
// - One-shot output follows internal count source
// - Entering one-shot mode sets request flag
// - Retrigger counts once more then reloads
package gtu_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   localparam logic [ADDR_W-1:0] OFS_START = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_MODE = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_TRIG = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_PRESCALE = 4'h7;
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [1:0] MODE_EVENT = 2'h1;
   localparam logic [1:0] MODE_ONESHOT = 2'h2;
   localparam int MODE_LSB = 0;
   localparam int DIR_BIT = 2;
   localparam int ZPH_BIT = 3;
   localparam int TRG_EXT_BIT = 0;
   localparam int TRG_SEL_LSB = 1;
   localparam int IRQ_W = 3;
   localparam int IRQ_REQ = 0;
   localparam int IRQ_UDF = 1;
   localparam int IRQ_OVF = 2;
   localparam logic [CNT_W-1:0] CNT_ONES = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] PRESCALE_RST = 16'h0000;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam int CLK_MHZ = 25;
   localparam int RETRIG_GUARD_NS = 300;
   localparam int RETRIG_GUARD_CYC = (RETRIG_GUARD_NS * CLK_MHZ) / 1000;
endpackage

// ==== verilog/gtu_sync.sv ====
/*
 Two-flop synchroniser for a level from outside the clock domain.
 Assumes the input may change at any time relative to clock_i.
*/
module gtu_sync (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic async_i,
   output logic sync_o
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb
   begin
      meta_d = async_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;
endmodule

// ==== bench/gtu_timer_monitor.sv ====
/*
 Checker for one timer channel, bound to its ports.
 Assumes software keeps the one-cycle strobes of the register port.
*/
module gtu_mon
   import gtu_pkg::*;
(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [gtu_pkg::ADDR_W-1:0] addr_i,
   input wire logic [gtu_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [gtu_pkg::DATA_W-1:0] rdata_o,
   input wire logic timer_output_pin_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic st_q, fr_q, en_q, sp_q;
   logic [1:0] md_q;
   logic [15:0] cn_q;
   wire logic stop = wr_i && addr_i == OFS_START && !wdata_i[0] && st_q
      && md_q == MODE_ONESHOT;
   // Mirror of software state; mode writes while running are dropped
   always_ff @(posedge clock_i)
   begin
      sp_q <= stop && !srst_i;
      if (srst_i)
      begin
         st_q <= 1'b0;
         fr_q <= 1'b0;
         en_q <= 1'b0;
         md_q <= MODE_TIMER;
         cn_q <= CNT_ZERO;
      end
      else
      begin
         if (sp_q)
            fr_q <= 1'b1;
         if (wr_i && addr_i == OFS_START)
         begin
            st_q <= wdata_i[0];
            fr_q <= 1'b0;
         end
         if (wr_i && addr_i == OFS_MODE && !st_q)
            md_q <= wdata_i[1:0];
         if (wr_i && addr_i == OFS_IRQ_EN)
            en_q <= |wdata_i[IRQ_W-1:0];
         if (wr_i && addr_i == OFS_COUNT)
         begin
            cn_q <= wdata_i[15:0];
            fr_q <= !st_q;
         end
      end
   end
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (srst_i);
   a_reset_quiet: assert property (
      $fell(srst_i) |-> !irq_o && !timer_output_pin_o)
      else $error("output active after reset");
   a_stopped_flat: assert property (
      !st_q && $past(!st_q, 3) |-> $stable(timer_output_pin_o))
      else $error("output moved while stopped");
   a_stop_low: assert property (
      stop |-> ##2 !timer_output_pin_o)
      else $error("output high after one-shot stop");
   a_stop_irq: assert property (
      stop && en_q |-> ##[2:3] irq_o)
      else $error("no request after one-shot stop");
   a_mode_irq: assert property (
      wr_i && addr_i == OFS_MODE && !st_q && en_q && md_q != MODE_ONESHOT
      && wdata_i[1:0] == MODE_ONESHOT |-> ##[1:2] irq_o)
      else $error("no request on entering one-shot");
   a_irq_gate: assert property (
      !en_q |-> !irq_o)
      else $error("interrupt while disabled");
   a_read_written: assert property (
      fr_q && rd_i && addr_i == OFS_COUNT |=> rdata_o == {16'h0000, cn_q})
      else $error("stopped count read wrong");
   a_timer_range: assert property (
      rd_i && addr_i == OFS_COUNT && st_q && md_q == MODE_TIMER
      |=> rdata_o[15:0] <= cn_q || rdata_o[15:0] == CNT_ONES)
      else $error("running count out of range");
endmodule
bind gtu_timer gtu_mon mon (.clock_i, .srst_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .timer_output_pin_o, .irq_o);

// ==== bench/gtu_trig_src.sv ====
/*
 Trigger pin source for the timer channel.
 Assumes the pin idles low, as if pulled down, between pulses.
*/
module gtu_trig_src (
   input wire logic clock_i,
   output logic pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin_o = 1'b0;
   // Wide pulse and long gap, so the synchroniser always sees it
   task automatic pulse();
      @(posedge clock_i);
      pin_o <= 1'b1;
      repeat (3) @(posedge clock_i);
      pin_o <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask
endmodule

// ==== bench/tb.sv ====
/*
 Self-checking bench for one timer channel.
 Assumes the checker is bound and the trigger source idles low.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import gtu_pkg::*;
   logic clock_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0, rdata_o, v;
   logic pin, tout, irq;
   logic [1:0] peer = 2'h0;
   int fails = 0, cmp_count = 0;
   always #20 clock_i = ~clock_i;
   gtu_timer dut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .trigger_input_pin_i(pin), .trig_peer_i(peer),
      .timer_output_pin_o(tout), .irq_o(irq));
   gtu_trig_src src (.clock_i(clock_i), .pin_o(pin));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   // Data stand one cycle only, so they are taken mid-cycle
   task automatic rd(input logic [3:0] a);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      @(negedge clock_i);
      v = rdata_o;
   endtask
   task automatic t_reset();
      @(negedge clock_i);
      chk(tout, 1'b0);
      rd(OFS_COUNT);
      chk(v, 32'h0);
      rd(4'hF);
      chk(v, 32'h0);
      wr(OFS_COUNT, 32'h1234);
      rd(OFS_COUNT);
      chk(v, 32'h1234);
   endtask
   task automatic t_timer();
      int seen = 0;
      wr(OFS_COUNT, 32'h3);
      wr(OFS_START, 32'h1);
      addr_i <= OFS_COUNT;
      rd_i <= 1'b1;
      repeat (12)
      begin
         @(negedge clock_i);
         if (rdata_o[15:0] === CNT_ONES)
            seen++;
      end
      @(posedge clock_i);
      rd_i <= 1'b0;
      chk(32'(seen != 0), 32'h1);
      wr(OFS_MODE, 32'h2);
      rd(OFS_MODE);
      chk(v, 32'h0);
      wr(OFS_START, 32'h0);
   endtask
   task automatic t_event();
      wr(OFS_IRQ_CLR, 32'h7);
      wr(OFS_MODE, 32'h9);
      wr(OFS_TRIG, 32'h1);
      wr(OFS_COUNT, 32'h1);
      wr(OFS_START, 32'h1);
      // Gated: no pin edge, no count
      repeat (4) @(negedge clock_i);
      rd(OFS_COUNT);
      chk(v, 32'h1);
      src.pulse();
      rd(OFS_STATUS);
      chk(v & 32'h2, 32'h0);
      repeat (2) src.pulse();
      rd(OFS_STATUS);
      chk(v & 32'h2, 32'h2);
      wr(OFS_START, 32'h0);
      wr(OFS_MODE, 32'hD);
      wr(OFS_COUNT, 32'hFFFE);
      wr(OFS_START, 32'h1);
      repeat (3) src.pulse();
      rd(OFS_STATUS);
      chk(v & 32'h4, 32'h4);
      wr(OFS_START, 32'h0);
   endtask
   task automatic t_oneshot();
      wr(OFS_TRIG, 32'h0);
      wr(OFS_IRQ_CLR, 32'h7);
      wr(OFS_IRQ_EN, 32'h1);
      wr(OFS_MODE, 32'h2);
      rd(OFS_STATUS);
      chk(v, 32'h1);
      chk(irq, 1'b1);
      wr(OFS_IRQ_CLR, 32'h1);
      @(negedge clock_i);
      chk(irq, 1'b0);
      wr(OFS_COUNT, 32'h64);
      wr(OFS_START, 32'h1);
      repeat (3) @(negedge clock_i);
      chk(tout, 1'b1);
      wr(OFS_START, 32'h0);
      repeat (2) @(negedge clock_i);
      chk(tout, 1'b0);
      rd(OFS_COUNT);
      chk(v, 32'h64);
      rd(OFS_STATUS);
      chk(v, 32'h1);
      chk(irq, 1'b1);
      wr(OFS_IRQ_EN, 32'h0);
      @(negedge clock_i);
      chk(irq, 1'b0);
      wr(OFS_IRQ_CLR, 32'h7);
   endtask
   task automatic t_retrig();
      int n = 0;
      wr(OFS_TRIG, 32'h1);
      wr(OFS_COUNT, 32'h14);
      wr(OFS_START, 32'h1);
      repeat (3) @(negedge clock_i);
      chk(tout, 1'b0);
      src.pulse();
      @(negedge clock_i);
      chk(tout, 1'b1);
      src.pulse();
      // Without the retrigger the output would be low by now
      repeat (14) @(negedge clock_i);
      chk(tout, 1'b1);
      while (tout === 1'b1 && n < 40)
      begin
         @(negedge clock_i);
         n++;
      end
      chk(tout, 1'b0);
      wr(OFS_START, 32'h0);
   endtask
   // Peer trigger with a halved count source: 4 steps of 2 clocks
   task automatic t_peer();
      int n = 0;
      wr(OFS_PRESCALE, 32'h1);
      wr(OFS_TRIG, 32'h3);
      wr(OFS_COUNT, 32'h4);
      wr(OFS_START, 32'h1);
      repeat (6) @(negedge clock_i);
      chk(tout, 1'b0);
      // Two-clock pulse always covers one count source tick
      @(posedge clock_i);
      peer <= 2'h1;
      repeat (2) @(posedge clock_i);
      peer <= 2'h0;
      while (tout !== 1'b1 && n < 8)
      begin
         @(negedge clock_i);
         n++;
      end
      chk(tout, 1'b1);
      n = 0;
      while (tout === 1'b1 && n < 40)
      begin
         @(negedge clock_i);
         n++;
      end
      chk(n, 32'h8);
      wr(OFS_START, 32'h0);
      wr(OFS_PRESCALE, 32'h0);
   endtask
   task automatic end_of_test();
      $display("compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge clock_i);
      srst_i <= 1'b0;
      t_reset();
      t_timer();
      t_event();
      t_oneshot();
      t_retrig();
      t_peer();
      end_of_test();
   end
   initial
   begin
      repeat (4000) @(posedge clock_i);
      fails++;
      end_of_test();
   end
endmodule
